// ===== hw/lin_ctrl_pkg.sv
// Constants for the LIN control and auto-sync block
// What this block does
// - Eight-bit control register: enable, master, auto-update, master-update, break, length; resets zero.
// - Header detection and break transmission work only while LIN enable is one.
// - Role select bit accepts a new value only while LIN enable is zero.
// - Auto-sync update enable is write-only; reads return zero in its place.
// - With auto-update on, valid SYNC copies measured divisor to active divisor, raises update interrupt.
// - With auto-update off, valid SYNC only stores measured divisor and raises sync interrupt.
// - Role select one means master mode, zero means slave mode.
// - Measured divisor holds last valid sync result, read-only, acquired only in slave mode.
// - Bit time equals divisor clocks; a zero divisor write is ignored.
package lin_ctrl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [17:0] IDX_CTRL = 18'h0A090;
  localparam logic [17:0] IDX_IRQ_STATUS = 18'h0A0A0;
  localparam logic [17:0] IDX_IRQ_MASK = 18'h0A0A1;
  localparam logic [17:0] IDX_ACTIVE_DIV = 18'h0A0A2;
  localparam logic [17:0] IDX_MEASURED_DIV = 18'h0A0A3;
  localparam int ADDR_W = 20;
  // Control field positions
  localparam int CTRL_ENABLE = 7;
  localparam int CTRL_MASTER = 6;
  localparam int CTRL_AUTO_UPDATE = 5;
  localparam int CTRL_MASTER_UPDATE = 4;
  localparam int CTRL_BREAK = 3;
  localparam int CTRL_BL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Interrupt bit positions
  localparam int IRQ_BAUD_UPDATE = 0;
  localparam int IRQ_SYNC_RECEIVED = 1;
  localparam int IRQ_BREAK_DONE = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Baud and timing
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [15:0] MEASURED_RESET = 16'h0000;
  localparam logic [4:0] BREAK_BASE_BITS = 5'h0D;
  localparam logic [3:0] BREAK_DETECT_BITS = 4'hB;
  localparam logic [2:0] SYNC_FALL_EDGES = 3'h4;
  localparam int SYNC_SHIFT = 3;
  localparam int CNT_W = 20;
endpackage

// ===== hw/sync_field_meter.sv
// Break detector and SYNC field bit-time meter
module sync_field_meter
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic rx,
  input wire logic [15:0] bit_div,
  output logic sync_valid,
  output logic [15:0] sync_div
);
  typedef enum logic [1:0] {IDLE, BREAK_LOW, WAIT_START, MEASURE} meter_e;
  meter_e state_r;
  meter_e state_nxt;
  logic rx_d_r;
  logic [lin_ctrl_pkg::CNT_W-1:0] cnt_r;
  logic [lin_ctrl_pkg::CNT_W-1:0] cnt_nxt;
  logic [2:0] falls_r;
  logic [2:0] falls_nxt;
  logic valid_r;
  logic [15:0] div_r;
  wire fall = rx_d_r & ~rx;
  wire cnt_max = &cnt_r;
  wire [lin_ctrl_pkg::CNT_W-1:0] break_thr = lin_ctrl_pkg::CNT_W'(bit_div) *
                                             lin_ctrl_pkg::CNT_W'(lin_ctrl_pkg::BREAK_DETECT_BITS);
  wire [15:0] meas = cnt_r[lin_ctrl_pkg::SYNC_SHIFT +: 16];
  wire done = (state_r == MEASURE) && fall && (falls_r == lin_ctrl_pkg::SYNC_FALL_EDGES - 3'h1);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_max ? cnt_r : cnt_r + 1'b1;
    falls_nxt = falls_r;
    case (state_r)
      IDLE:
      begin
        cnt_nxt = '0;
        if (!rx)
          state_nxt = BREAK_LOW;
      end
      BREAK_LOW:
        if (rx)
        begin
          cnt_nxt = '0;
          state_nxt = (cnt_r >= break_thr) ? WAIT_START : IDLE;
        end
      WAIT_START:
      begin
        cnt_nxt = '0;
        falls_nxt = '0;
        if (cnt_max)
          state_nxt = IDLE;
        else if (fall)
        begin
          // Start-edge cycle counts, so eight bit times give exactly eight divisors
          cnt_nxt = lin_ctrl_pkg::CNT_W'(1);
          state_nxt = MEASURE;
        end
      end
      MEASURE:
      begin
        if (fall)
          falls_nxt = falls_r + 3'h1;
        if (done || cnt_max)
          state_nxt = IDLE;
      end
      default:
        state_nxt = IDLE;
    endcase
  end

  // ----------------------------------------
  // State and result
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= IDLE;
      rx_d_r <= 1'b1;
      cnt_r <= '0;
      falls_r <= '0;
      valid_r <= 1'b0;
      div_r <= lin_ctrl_pkg::MEASURED_RESET;
    end
    else
    begin
      rx_d_r <= rx;
      state_r <= enable ? state_nxt : IDLE;
      cnt_r <= cnt_nxt;
      falls_r <= falls_nxt;
      // Eight bit times from start edge to bit 7 edge; zero result is no valid sync
      valid_r <= enable && done && (meas != 16'h0000);
      if (enable && done && (meas != 16'h0000))
        div_r <= meas;
    end
  end

  assign sync_valid = valid_r;
  assign sync_div = div_r;
endmodule

// ===== hw/lin_control_auto_sync.sv
// LIN control register, auto-baud update and break sender with Avalon-MM slave
module lin_control_auto_sync
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [19:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic lin_rx,
  input wire logic uart_tx,
  output logic lin_tx,
  output logic [15:0] active_baud_divisor,
  output logic lin_function_enable,
  output logic master_role_select
);
  // ----------------------------------------
  // Bus handshake: one wait state on every access
  // ----------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  wire req = read | write;
  wire wr_fire = write & ack_r;
  wire [17:0] idx = address[19:2];
  wire hit_ctrl = idx == lin_ctrl_pkg::IDX_CTRL;
  wire hit_status = idx == lin_ctrl_pkg::IDX_IRQ_STATUS;
  wire hit_mask = idx == lin_ctrl_pkg::IDX_IRQ_MASK;
  wire hit_div = idx == lin_ctrl_pkg::IDX_ACTIVE_DIV;
  wire hit_meas = idx == lin_ctrl_pkg::IDX_MEASURED_DIV;
  wire wr_ctrl = wr_fire & hit_ctrl & byteenable[0];
  wire wr_status = wr_fire & hit_status & byteenable[0];
  wire wr_mask = wr_fire & hit_mask & byteenable[0];
  wire wr_div = wr_fire & hit_div & (&byteenable[1:0]);

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic enable_r;
  logic master_r;
  logic auto_update_r;
  logic master_update_r;
  logic break_cmd_r;
  logic [2:0] break_len_r;
  logic [15:0] div_r;
  logic [lin_ctrl_pkg::IRQ_W-1:0] status_r;
  logic [lin_ctrl_pkg::IRQ_W-1:0] mask_r;
  logic [lin_ctrl_pkg::IRQ_W-1:0] events;
  logic rx_s1_r;
  logic rx_s2_r;
  logic sync_valid;
  logic [15:0] measured_baud_divisor;
  logic tx_r;
  logic [15:0] tick_cnt_r;
  logic [4:0] bit_cnt_r;
  logic break_done;

  wire role_change_ok = wr_ctrl & ~enable_r;
  wire sync_accept = sync_valid & enable_r & ~master_r;
  wire baud_update = sync_accept & auto_update_r;
  wire sync_notice = sync_accept & ~auto_update_r;
  wire break_active = break_cmd_r & enable_r & master_r;
  wire tick = tick_cnt_r == div_r - 16'h0001;
  wire [4:0] break_bits = lin_ctrl_pkg::BREAK_BASE_BITS + {2'b00, break_len_r};
  wire [7:0] ctrl_read = {enable_r, master_r, 1'b0, master_update_r, break_cmd_r, break_len_r};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_read} :
                       hit_status ? {29'h00000000, status_r} :
                       hit_mask ? {29'h00000000, mask_r} :
                       hit_div ? {16'h0000, div_r} :
                       hit_meas ? {16'h0000, measured_baud_divisor} : 32'h00000000;

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  always_comb
  begin
    events = '0;
    events[lin_ctrl_pkg::IRQ_BAUD_UPDATE] = baud_update;
    events[lin_ctrl_pkg::IRQ_SYNC_RECEIVED] = sync_notice;
    events[lin_ctrl_pkg::IRQ_BREAK_DONE] = break_done;
  end

  // Last tick of the last bit clears the command and flags completion
  assign break_done = break_active & tick & (bit_cnt_r == break_bits - 5'h01);

  // Ack drops after each accept, so back-to-back requests each see one wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // Read data captured in the wait cycle and held until the next read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 32'h00000000;
    else if (read & ~ack_r)
      rdata_r <= rd_mux;
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_ENABLE];
      master_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_MASTER];
      auto_update_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_AUTO_UPDATE];
      master_update_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_MASTER_UPDATE];
      break_cmd_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_BREAK];
      break_len_r <= lin_ctrl_pkg::CTRL_RESET[lin_ctrl_pkg::CTRL_BL_LSB +: 3];
    end
    else
    begin
      if (wr_ctrl)
      begin
        enable_r <= writedata[lin_ctrl_pkg::CTRL_ENABLE];
        auto_update_r <= writedata[lin_ctrl_pkg::CTRL_AUTO_UPDATE];
        master_update_r <= writedata[lin_ctrl_pkg::CTRL_MASTER_UPDATE];
        break_len_r <= writedata[lin_ctrl_pkg::CTRL_BL_LSB +: 3];
      end
      if (role_change_ok)
        master_r <= writedata[lin_ctrl_pkg::CTRL_MASTER];
      // Completion wins over a same-cycle write so a finished break never restarts
      if (break_done)
        break_cmd_r <= 1'b0;
      else if (wr_ctrl)
        break_cmd_r <= writedata[lin_ctrl_pkg::CTRL_BREAK];
    end
  end

  // ----------------------------------------
  // Baud divisor and interrupts
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_r <= lin_ctrl_pkg::DIV_RESET;
      status_r <= lin_ctrl_pkg::IRQ_RESET;
      mask_r <= lin_ctrl_pkg::IRQ_RESET;
    end
    else
    begin
      // Auto update beats a software write landing in the same cycle
      if (baud_update)
        div_r <= measured_baud_divisor;
      else if (wr_div && writedata[15:0] != 16'h0000)
        div_r <= writedata[15:0];
      // Set wins over write-one-to-clear
      status_r <= (status_r & ~(wr_status ? writedata[lin_ctrl_pkg::IRQ_W-1:0] : '0)) | events;
      if (wr_mask)
        mask_r <= writedata[lin_ctrl_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------
  // Reset to the idle level, so no false break follows reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= lin_rx;
      rx_s2_r <= rx_s1_r;
    end
  end

  // ----------------------------------------
  // Break sender
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_r <= 1'b1;
      tick_cnt_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end
    else
    begin
      // Low through the done cycle too, so the break lasts the full count
      tx_r <= break_active ? 1'b0 : uart_tx;
      if (!break_active || tick)
        tick_cnt_r <= 16'h0000;
      else
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      if (!break_active || break_done)
        bit_cnt_r <= 5'h00;
      else if (tick)
        bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // ----------------------------------------
  // SYNC field meter
  // ----------------------------------------
  // Only slave mode measures; a master owns the bit rate
  sync_field_meter u_meter
  (
    .clk(clk),
    .reset_n(reset_n),
    .enable(enable_r & ~master_r),
    .rx(rx_s2_r),
    .bit_div(div_r),
    .sync_valid(sync_valid),
    .sync_div(measured_baud_divisor)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign waitrequest = req & ~ack_r;
  assign readdata = rdata_r;
  assign irq = |(status_r & mask_r);
  assign lin_tx = tx_r;
  assign active_baud_divisor = div_r;
  assign lin_function_enable = enable_r;
  assign master_role_select = master_r;
endmodule

// ===== tb/lin_control_auto_sync_asserts.sv
// Port checker for the LIN control block
module lin_control_auto_sync_asserts
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [19:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic uart_tx,
  input wire logic lin_tx,
  input wire logic [15:0] active_baud_divisor,
  input wire logic lin_function_enable,
  input wire logic master_role_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  AST_ONE_WAIT: assert property ($rose(read || write) |-> s_one_wait)
    else $error("bus wait state wrong");
  AST_CTRL_READ: assert property (read && !waitrequest && address[19:2] == lin_ctrl_pkg::IDX_CTRL
    |-> readdata[31:8] == 24'h0 && !readdata[5])
    else $error("control read shows hidden bits");
  AST_CTRL_BY_WRITE: assert property ($changed({lin_function_enable, master_role_select})
    |-> $past(write && !waitrequest))
    else $error("control bit changed without write");
  AST_ROLE_LOCK: assert property ($past(lin_function_enable) |-> $stable(master_role_select))
    else $error("role changed while enabled");
  AST_DIV_NONZERO: assert property (active_baud_divisor != 16'h0)
    else $error("divisor is zero");
  AST_DIV_SOURCE: assert property ($changed(active_baud_divisor)
    |-> $past(write) || $past(lin_function_enable && !master_role_select))
    else $error("divisor changed with no cause");
  AST_TX_PASS: assert property ($past(reset_n) && !$past(lin_function_enable) |-> lin_tx == $past(uart_tx))
    else $error("tx not passed through");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(write && !waitrequest))
    else $error("irq dropped without write");
endmodule

bind lin_control_auto_sync lin_control_auto_sync_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .irq(irq), .uart_tx(uart_tx), .lin_tx(lin_tx), .active_baud_divisor(active_baud_divisor),
  .lin_function_enable(lin_function_enable), .master_role_select(master_role_select));

// ===== tb/lin_master_node.sv
// Far-side LIN master node that sends break and sync headers
module lin_master_node
(
  input wire logic clk,
  output logic rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled-up bus, so idle reads high
  initial rx = 1'b1;
  // Break 13 bits, delimiter, then 0x55 framed, LSB first
  task automatic send_header(input int bit_clks);
    logic [23:0] pat;
    pat = {1'b1, 8'h55, 1'b0, 1'b1, 13'h0};
    for (int i = 0; i < 24; i++)
    begin
      rx <= pat[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask
endmodule

// ===== tb/lin_control_auto_sync_tb_top.sv
// Self-checking bench for the LIN control block
module lin_control_auto_sync_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, read, write, uart_tx, irq, waitrequest, lin_tx, lin_rx, en, master;
  logic [19:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rv;
  logic [15:0] div;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  lin_control_auto_sync dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .lin_rx(lin_rx), .uart_tx(uart_tx), .lin_tx(lin_tx), .active_baud_divisor(div),
    .lin_function_enable(en), .master_role_select(master));
  lin_master_node u_node (.clk(clk), .rx(lin_rx));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run needs about 700 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      results();
    end
  end
  task results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Held until waitrequest is sampled low, then an idle cycle
  task bus(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'h0};
    write <= wr;
    read <= ~wr;
    writedata <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    check("edges to accept", n, 32'h2);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task rdchk(input string name, input logic [17:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(name, rv, exp);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_control;
    rdchk("ctrl", lin_ctrl_pkg::IDX_CTRL, 32'h0);
    rdchk("meas", lin_ctrl_pkg::IDX_MEASURED_DIV, 32'h0);
    check("div", div, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'h77);
    rdchk("ctrl", lin_ctrl_pkg::IDX_CTRL, 32'h57);
    check("master", master, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'h80);
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'hC0);
    rdchk("ctrl", lin_ctrl_pkg::IDX_CTRL, 32'h80);
    check("en", en, 32'h1);
  endtask
  task t_sync_off;
    bus(1'b1, lin_ctrl_pkg::IDX_IRQ_MASK, 32'h7);
    u_node.send_header(6);
    repeat (8) @(posedge clk);
    rdchk("meas", lin_ctrl_pkg::IDX_MEASURED_DIV, 32'h6);
    rdchk("stat", lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h2);
    check("div", div, 32'h1);
    check("irq", irq, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h2);
    check("irq", irq, 32'h0);
  endtask
  task t_sync_auto;
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'hA0);
    bus(1'b1, lin_ctrl_pkg::IDX_IRQ_MASK, 32'h0);
    u_node.send_header(9);
    repeat (8) @(posedge clk);
    check("div", div, 32'h9);
    check("irq", irq, 32'h0);
    rdchk("stat", lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_IRQ_MASK, 32'h1);
    check("irq", irq, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h1);
    rdchk("stat", lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h0);
  endtask
  task t_div_off;
    bus(1'b1, lin_ctrl_pkg::IDX_ACTIVE_DIV, 32'h0);
    rdchk("div", lin_ctrl_pkg::IDX_ACTIVE_DIV, 32'h9);
    bus(1'b1, lin_ctrl_pkg::IDX_ACTIVE_DIV, 32'h2);
    byteenable <= 4'h1;
    bus(1'b1, lin_ctrl_pkg::IDX_ACTIVE_DIV, 32'h5);
    byteenable <= 4'hF;
    rdchk("div lane", lin_ctrl_pkg::IDX_ACTIVE_DIV, 32'h2);
    rdchk("unmapped", 18'h00010, 32'h0);
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'h0);
    u_node.send_header(7);
    repeat (8) @(posedge clk);
    rdchk("meas", lin_ctrl_pkg::IDX_MEASURED_DIV, 32'h9);
    rdchk("stat", lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h0);
    check("div", div, 32'h2);
    uart_tx <= 1'b0;
    repeat (2) @(posedge clk);
    check("tx", lin_tx, 32'h0);
    uart_tx <= 1'b1;
  endtask
  task t_break;
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'h48);
    repeat (2) @(posedge clk);
    check("brk off", lin_tx, 32'h1);
    bus(1'b1, lin_ctrl_pkg::IDX_CTRL, 32'hC9);
    repeat (2) @(posedge clk);
    check("brk", lin_tx, 32'h0);
    // Fourteen bit times of two clocks from the accept edge
    repeat (26) @(posedge clk);
    check("brk last", lin_tx, 32'h0);
    @(posedge clk);
    check("brk end", lin_tx, 32'h1);
    rdchk("ctrl", lin_ctrl_pkg::IDX_CTRL, 32'hC1);
    rdchk("stat", lin_ctrl_pkg::IDX_IRQ_STATUS, 32'h4);
  endtask
  initial
  begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 20'h0;
    byteenable = 4'hF;
    writedata = 32'h0;
    uart_tx = 1'b1;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_control();
    t_sync_off();
    t_sync_auto();
    t_div_off();
    t_break();
    results();
  end
endmodule
